// file: src/cbs_pkg.sv
// Package: constants, register layout and carrier types of the clock buffer config block
package cbs_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  // Least start-up delay, rounded up to whole cycles
  localparam int STARTUP_DELAY_NS = 100_000;
  localparam int STARTUP_CYCLES = (STARTUP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Whole power-on budget until outputs run
  localparam int POWERUP_BUDGET_NS = 1_800_000;

  // ---------------------------------------------------------------
  // Register indices and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_MODE = 8'h00;
  localparam logic [7:0] IDX_OEN = 8'h01;
  localparam int MODE_RB_LO = 6;
  localparam int SW_EN_BIT = 3;
  localparam int MODE_RW_LO = 1;
  localparam int FREQ_BIT = 0;
  localparam int OEN_HI_LO = 4;
  localparam int OEN_LO_LO = 1;
  localparam logic SW_EN_RESET = 1'b0;
  localparam logic [1:0] MODE_RW_RESET = 2'b11;
  localparam logic [5:0] OUT_EN_RESET = 6'h3F;
  // Reserved bit values of the mode and output enable bytes, and the unmapped byte
  localparam logic OEN_RSV3 = 1'b0;
  localparam logic OEN_RSV0 = 1'b1;
  localparam logic [1:0] MODE_RSV = 2'b00;
  localparam logic [7:0] UNMAPPED_BYTE = 8'h00;

  // ---------------------------------------------------------------
  // Loop modes (three-level strap encoding)
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_LBW = 2'b00;
  localparam logic [1:0] MODE_BYPASS = 2'b01;
  localparam logic [1:0] MODE_HBW = 2'b11;

  // ---------------------------------------------------------------
  // SMBus defaults
  // ---------------------------------------------------------------
  localparam logic [6:0] SMB_ADDR_DEFAULT = 7'h6A;
  localparam logic [7:0] READ_COUNT_DEFAULT = 8'h08;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {PU_OFF, PU_DELAY, PU_WAIT, PU_LOCK, PU_RUN} cbs_pu_t;
  typedef enum logic [2:0] {SMB_IDLE, SMB_RX, SMB_ACKO, SMB_TX, SMB_ACKI} cbs_smb_st_t;
  typedef enum logic [1:0] {ROLE_ADDR, ROLE_INDEX, ROLE_COUNT, ROLE_WDATA} cbs_role_t;

  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic sda;
    logic start;
    logic stop;
  } cbs_evt_t;

  typedef struct packed {
    cbs_smb_st_t st;
    cbs_role_t role;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic [7:0] remain;
    logic rd;
    logic acked;
  } cbs_smb_t;

  typedef struct packed {
    logic sw_en;
    logic [1:0] mode_rw;
    logic [5:0] out_en;
    logic strap_done;
    logic [1:0] strap_mode;
    logic strap_freq;
  } cbs_cfg_t;

endpackage

// file: src/cbs_smb_pins.sv
// Serial pin conditioner: synchronises clock and data, finds edges, start and stop
module cbs_smb_pins
  import cbs_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output cbs_evt_t evt_o
);

  // ---------------------------------------------------------------
  // Two-stage synchronisers plus one history stage
  // ---------------------------------------------------------------
  logic [2:0] scl_q;
  logic [2:0] sda_q;
  logic [2:0] next_scl_q;
  logic [2:0] next_sda_q;

  // Shift in; only stage 1 and 2 are read by logic
  always_comb begin
    next_scl_q = {scl_q[1:0], scl_i};
    next_sda_q = {sda_q[1:0], sda_i};
  end

  // Idle bus is high on both lines
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end else begin
      scl_q <= next_scl_q;
      sda_q <= next_sda_q;
    end
  end

  // Events from synchronised and delayed stages
  always_comb begin
    evt_o.scl_rise = scl_q[1] & ~scl_q[2];
    evt_o.scl_fall = ~scl_q[1] & scl_q[2];
    evt_o.sda = sda_q[1];
    evt_o.start = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
    evt_o.stop = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
  end

endmodule

// file: src/cbs_clock_buffer_cfg.sv
// Clock buffer configuration: power-up sequencer, SMBus target and config bytes
// Summary of operation
// - Supply valid starts fixed start-up delay
// - Then wait for reference and power-good rise
// - Outputs run only once loop locked
// - Power-on to outputs under 1.8 ms
// - No reference clock keeps outputs disabled
// - Write: ack address, index and count
// - Write data to consecutive indices, ack each
// - Read: ack address, index, read address
// - Read returns count then consecutive bytes
// - Byte0 bits 7:6 latched strap mode
// - Byte0 bit3 selects strap or software mode
// - Software mode from byte0 bits 2:1
// - Byte0 bit0 latched frequency strap readback
// - Enable bit zero forces pair low
// - Byte1 bit map of outputs five..zero
// - Output runs: enable bit and pin low
// - Straps latched on first power-good rise
// - Strap picks high bandwidth, bypass, low
module cbs_clock_buffer_cfg
  import cbs_pkg::*;
#(
  parameter int STARTUP_CYCLES_P = STARTUP_CYCLES,
  parameter logic [6:0] SMB_ADDR = SMB_ADDR_DEFAULT,
  parameter logic [7:0] READ_COUNT = READ_COUNT_DEFAULT
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic supply_valid_i,
  input wire logic power_good_powerdown_n_i,
  input wire logic ref_clk_detect_i,
  input wire logic pll_lock_i,
  input wire logic frequency_select_strap_i,
  input wire logic [1:0] loop_bandwidth_strap_i,
  input wire logic [5:0] oe_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic [5:0] differential_output_pair_en_o,
  output logic [1:0] pll_mode_o,
  output logic pll_enable_o,
  output logic freq_100m_o,
  output logic ready_o
);

  localparam int DLY_W = $clog2(STARTUP_CYCLES_P + 1);

  // Refuse a delay that cannot fit the power-on budget
  if (STARTUP_CYCLES_P < 1 || STARTUP_CYCLES_P * CLK_PERIOD_NS >= POWERUP_BUDGET_NS) begin : g_chk
    $error("startup cycles out of range");
  end

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [12:0] sync_m;
  logic [12:0] sync_s;
  logic pg_d;
  logic supply_s;
  logic pg_s;
  logic ref_s;
  logic lock_s;
  logic fsel_s;
  logic [1:0] bw_s;
  logic [5:0] oe_n_s;
  logic pg_rise;

  // Straps and status pins are asynchronous to clk_i
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      sync_m <= 13'h0000;
      sync_s <= 13'h0000;
      pg_d <= 1'b0;
    end else begin
      sync_m <= {supply_valid_i, power_good_powerdown_n_i, ref_clk_detect_i, pll_lock_i,
                 frequency_select_strap_i, loop_bandwidth_strap_i, oe_n_i};
      sync_s <= sync_m;
      pg_d <= sync_s[11];
    end
  end

  assign {supply_s, pg_s, ref_s, lock_s, fsel_s, bw_s, oe_n_s} = sync_s;
  assign pg_rise = pg_s & ~pg_d;

  // ---------------------------------------------------------------
  // Serial pin conditioner
  // ---------------------------------------------------------------
  cbs_evt_t evt;

  cbs_smb_pins u_pins (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .evt_o(evt)
  );

  // Read decode for data loads; the count load uses READ_COUNT
  function automatic logic [7:0] read_byte(input logic [7:0] idx, input cbs_cfg_t c);
    logic [7:0] b;
    b = UNMAPPED_BYTE;
    case (idx)
      IDX_MODE: b = {c.strap_mode, MODE_RSV, c.sw_en, c.mode_rw, c.strap_freq};
      IDX_OEN: b = {c.out_en[5:2], OEN_RSV3, c.out_en[1:0], OEN_RSV0};
      default: b = UNMAPPED_BYTE;
    endcase
    return b;
  endfunction

  // ---------------------------------------------------------------
  // SMBus target byte engine
  // ---------------------------------------------------------------
  cbs_smb_t smb;
  cbs_smb_t next_smb;
  cbs_cfg_t cfg;
  cbs_cfg_t next_cfg;
  logic wr_stb;
  logic [7:0] wr_idx;
  logic [7:0] wr_data;
  logic next_sda_oe;

  always_comb begin
    next_smb = smb;
    wr_stb = 1'b0;
    wr_idx = smb.ptr;
    wr_data = smb.shreg;
    if (evt.stop) begin
      next_smb.st = SMB_IDLE;
    end else if (evt.start) begin
      // Repeated start restarts address phase
      next_smb.st = SMB_RX;
      next_smb.role = ROLE_ADDR;
      next_smb.bit_cnt = 4'h0;
    end else begin
      case (smb.st)
        SMB_RX: begin
          if (evt.scl_rise && smb.bit_cnt < 4'h8) begin
            next_smb.shreg = {smb.shreg[6:0], evt.sda};
            next_smb.bit_cnt = smb.bit_cnt + 4'h1;
          end else if (evt.scl_fall && smb.bit_cnt == 4'h8) begin
            next_smb.bit_cnt = 4'h0;
            next_smb.st = SMB_ACKO;
            case (smb.role)
              ROLE_ADDR: begin
                next_smb.rd = smb.shreg[0];
                if (smb.shreg[7:1] != SMB_ADDR) begin
                  next_smb.st = SMB_IDLE;
                end
              end
              ROLE_INDEX: next_smb.ptr = smb.shreg;
              ROLE_COUNT: next_smb.remain = smb.shreg;
              default: begin
                if (smb.remain != 8'h00) begin
                  wr_stb = 1'b1;
                  next_smb.ptr = smb.ptr + 8'h01;
                  next_smb.remain = smb.remain - 8'h01;
                end
              end
            endcase
          end
        end
        SMB_ACKO: begin
          if (evt.scl_fall) begin
            next_smb.bit_cnt = 4'h0;
            if (smb.role == ROLE_ADDR && smb.rd) begin
              next_smb.st = SMB_TX;
              next_smb.shreg = READ_COUNT;
            end else begin
              next_smb.st = SMB_RX;
              case (smb.role)
                ROLE_ADDR: next_smb.role = ROLE_INDEX;
                ROLE_INDEX: next_smb.role = ROLE_COUNT;
                default: next_smb.role = ROLE_WDATA;
              endcase
            end
          end
        end
        SMB_TX: begin
          if (evt.scl_fall) begin
            if (smb.bit_cnt == 4'h7) begin
              next_smb.st = SMB_ACKI;
              next_smb.bit_cnt = 4'h0;
            end else begin
              next_smb.shreg = {smb.shreg[6:0], 1'b0};
              next_smb.bit_cnt = smb.bit_cnt + 4'h1;
            end
          end
        end
        SMB_ACKI: begin
          if (evt.scl_rise) begin
            next_smb.acked = ~evt.sda;
          end else if (evt.scl_fall) begin
            if (smb.acked) begin
              next_smb.st = SMB_TX;
              next_smb.shreg = read_byte(smb.ptr, cfg);
              next_smb.ptr = smb.ptr + 8'h01;
            end else begin
              next_smb.st = SMB_IDLE;
            end
          end
        end
        default: next_smb.st = SMB_IDLE;
      endcase
    end
    // Open drain: pull low for ack or a zero data bit
    next_sda_oe = (next_smb.st == SMB_ACKO) || (next_smb.st == SMB_TX && !next_smb.shreg[7]);
  end

  // Serial engine state; sda_o is the pulled level, always low
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      smb <= '{st: SMB_IDLE, role: ROLE_ADDR, default: '0};
      sda_oe_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      smb <= next_smb;
      sda_oe_o <= next_sda_oe;
      sda_o <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Configuration bytes and strap latches
  // ---------------------------------------------------------------
  always_comb begin
    next_cfg = cfg;
    // straps caught once, on first rise
    if (!cfg.strap_done && pg_rise) begin
      next_cfg.strap_done = 1'b1;
      next_cfg.strap_mode = bw_s;
      next_cfg.strap_freq = fsel_s;
    end
    if (wr_stb) begin
      // read-only and reserved bits ignore writes
      case (wr_idx)
        IDX_MODE: begin
          next_cfg.sw_en = wr_data[SW_EN_BIT];
          next_cfg.mode_rw = wr_data[MODE_RW_LO +: 2];
        end
        IDX_OEN: begin
          // outputs 5..2 high nibble, 1..0 bits 2:1
          next_cfg.out_en = {wr_data[OEN_HI_LO +: 4], wr_data[OEN_LO_LO +: 2]};
        end
        default: next_cfg = next_cfg;
      endcase
    end
  end

  // Software bits reset to enabled outputs and high bandwidth
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      cfg <= '{sw_en: SW_EN_RESET, mode_rw: MODE_RW_RESET, out_en: OUT_EN_RESET,
               strap_mode: MODE_HBW, default: '0};
    end else begin
      cfg <= next_cfg;
    end
  end

  // ---------------------------------------------------------------
  // Power-up sequencer
  // ---------------------------------------------------------------
  cbs_pu_t pu;
  cbs_pu_t next_pu;
  logic [DLY_W-1:0] dly;
  logic [DLY_W-1:0] next_dly;
  logic pg_low_seen;
  logic next_pg_low_seen;
  logic [5:0] next_out;
  logic [1:0] next_mode;

  always_comb begin
    next_pu = pu;
    next_dly = dly;
    next_pg_low_seen = pg_low_seen | ~pg_s;
    case (pu)
      PU_OFF: begin
        next_pu = PU_DELAY;
        next_dly = '0;
      end
      PU_DELAY: begin
        // fixed delay leaves room in budget
        if (dly == DLY_W'(STARTUP_CYCLES_P - 1)) begin
          next_pu = PU_WAIT;
        end else begin
          next_dly = dly + 1'b1;
        end
      end
      PU_WAIT: begin
        // needs reference and a low-to-high power-good
        if (ref_s && pg_s && pg_low_seen) begin
          next_pu = PU_LOCK;
        end
      end
      PU_LOCK: begin
        if (!pg_s || !ref_s) begin
          next_pu = PU_WAIT;
        end else if (lock_s) begin
          next_pu = PU_RUN;
        end
      end
      PU_RUN: begin
        // lost reference drops back to waiting
        if (!pg_s || !ref_s || !lock_s) begin
          next_pu = PU_WAIT;
        end
      end
      default: next_pu = PU_OFF;
    endcase
    if (!supply_s) begin
      next_pu = PU_OFF;
      next_pg_low_seen = 1'b0;
    end
    // pair runs with bit set and pin low
    // cleared enable bit holds pair low/low
    next_out = (next_pu == PU_RUN) ? (cfg.out_en & ~oe_n_s) : 6'h00;
    // override bit picks the mode source
    next_mode = cfg.sw_en ? cfg.mode_rw : cfg.strap_mode;
  end

  // Outputs registered so pins never glitch on decode
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pu <= PU_OFF;
      dly <= '0;
      pg_low_seen <= 1'b0;
      differential_output_pair_en_o <= 6'h00;
      pll_mode_o <= MODE_RW_RESET;
      pll_enable_o <= 1'b0;
      freq_100m_o <= 1'b0;
      ready_o <= 1'b0;
    end else begin
      pu <= next_pu;
      dly <= next_dly;
      pg_low_seen <= next_pg_low_seen;
      differential_output_pair_en_o <= next_out;
      pll_mode_o <= next_mode;
      pll_enable_o <= (next_pu == PU_LOCK) || (next_pu == PU_RUN);
      freq_100m_o <= cfg.strap_freq;
      ready_o <= (next_pu == PU_RUN);
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  startup_delay_end_a: assert property (
    (pu == PU_DELAY && dly == DLY_W'(STARTUP_CYCLES_P - 1) && supply_s) |=> pu == PU_WAIT)
    else $error("start-up delay did not end on count");
  delay_bound_a: assert property (
    pu == PU_DELAY |-> dly < DLY_W'(STARTUP_CYCLES_P))
    else $error("start-up delay overran");
  wait_hold_a: assert property (
    (pu == PU_WAIT && supply_s && !(ref_s && pg_s)) |=> pu != PU_LOCK)
    else $error("left wait without reference and power-good");
  run_locked_a: assert property (
    ready_o |-> $past(lock_s) && $past(pll_enable_o))
    else $error("outputs ran without lock");
  no_ref_off_a: assert property (
    !ref_s |=> differential_output_pair_en_o == 6'h00)
    else $error("outputs on without reference clock");
  out_gate_a: assert property (
    ##1 (differential_output_pair_en_o & ~($past(cfg.out_en) & ~$past(oe_n_s))) == 6'h00)
    else $error("output ran against its enables");
  strap_hold_a: assert property (
    cfg.strap_done |=> $stable(cfg.strap_mode) && $stable(cfg.strap_freq))
    else $error("latched strap changed");
  strap_catch_a: assert property (
    (!cfg.strap_done && pg_rise) |=> cfg.strap_done && cfg.strap_mode == $past(bw_s))
    else $error("strap not latched on power-good rise");
  mode_select_a: assert property (
    ##1 pll_mode_o == ($past(cfg.sw_en) ? $past(cfg.mode_rw) : $past(cfg.strap_mode)))
    else $error("loop mode source wrong");
  ack_drive_a: assert property (
    (smb.st == SMB_RX && smb.bit_cnt == 4'h8 && evt.scl_fall && smb.role != ROLE_ADDR
     && !evt.start && !evt.stop) |=> sda_oe_o)
    else $error("acknowledge not driven");
  count_first_a: assert property (
    (smb.st == SMB_ACKO && smb.rd && smb.role == ROLE_ADDR && evt.scl_fall && !evt.stop
     && !evt.start) |=> smb.st == SMB_TX && smb.shreg == READ_COUNT)
    else $error("read did not start with count");
  write_step_a: assert property (
    wr_stb |=> smb.ptr == $past(smb.ptr) + 8'h01 && ($past(wr_idx) != IDX_OEN
      || cfg.out_en == {$past(wr_data[7:4]), $past(wr_data[2:1])}))
    else $error("write did not advance index");

endmodule

// file: test/cbs_smb_host.sv
// SMBus host controller model that drives the serial link of the config block
module cbs_smb_host (
  output logic scl_o,
  output logic sda_o,
  input wire logic sda_i
);
  timeunit 1ns;
  timeprecision 100ps;
  // Quarter of the 125 ns link clock; data moves mid-low so start/stop never alias
  localparam realtime Q = 31.25;

  // Both lines released at idle, the pull-ups hold them high
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic start();
    #Q sda_o = 1'b1;
    #Q scl_o = 1'b1;
    #Q sda_o = 1'b0;
    #Q scl_o = 1'b0;
  endtask

  task automatic stop();
    #Q sda_o = 1'b0;
    #Q scl_o = 1'b1;
    #Q sda_o = 1'b1;
    #Q;
  endtask

  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #Q sda_o = b[i];
      #Q scl_o = 1'b1;
      #(2 * Q) scl_o = 1'b0;
    end
    #Q sda_o = 1'b1;
    #Q scl_o = 1'b1;
    #Q ack = ~sda_i;
    #Q scl_o = 1'b0;
  endtask

  task automatic recv(input logic ack, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      #Q sda_o = 1'b1;
      #Q scl_o = 1'b1;
      #Q b[i] = sda_i;
      #Q scl_o = 1'b0;
    end
    #Q sda_o = ~ack;
    #Q scl_o = 1'b1;
    #(2 * Q) scl_o = 1'b0;
  endtask
endmodule

// file: test/tb.sv
// Self-checking bench of the clock buffer config block
`define CHK(got, exp, msg) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      miscompares++; \
      $display("wrong value at %0t: %s", $time, msg); \
    end \
  end

module tb
  import cbs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // Short start-up delay keeps the run brief
  localparam int STUP = 20;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic supply = 1'b0;
  logic pg = 1'b0;
  logic ref_ok = 1'b0;
  logic lock = 1'b0;
  logic fsel = 1'b1;
  logic [1:0] bw = MODE_BYPASS;
  logic [5:0] oe_n = 6'h00;
  logic scl;
  logic host_sda;
  logic sda;
  logic dut_sda;
  logic dut_oe;
  logic [5:0] pair_en;
  logic [1:0] pll_mode;
  logic pll_en;
  logic f100;
  logic ready;
  int miscompares = 0;
  int cmp_count = 0;
  logic [7:0] rq [$];

  // ----------------------------------------
  // Clock, wire resolution, instances
  // ----------------------------------------
  initial begin
    forever #5 clk_i = ~clk_i;
  end

  // Open-drain data line with pull-up
  assign sda = host_sda & ~(dut_oe & ~dut_sda);

  cbs_clock_buffer_cfg #(
    .STARTUP_CYCLES_P(STUP),
    .SMB_ADDR(SMB_ADDR_DEFAULT),
    .READ_COUNT(READ_COUNT_DEFAULT)
  ) i_dut (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .supply_valid_i(supply),
    .power_good_powerdown_n_i(pg),
    .ref_clk_detect_i(ref_ok),
    .pll_lock_i(lock),
    .frequency_select_strap_i(fsel),
    .loop_bandwidth_strap_i(bw),
    .oe_n_i(oe_n),
    .scl_i(scl),
    .sda_i(sda),
    .sda_o(dut_sda),
    .sda_oe_o(dut_oe),
    .differential_output_pair_en_o(pair_en),
    .pll_mode_o(pll_mode),
    .pll_enable_o(pll_en),
    .freq_100m_o(f100),
    .ready_o(ready)
  );

  cbs_smb_host i_host (
    .scl_o(scl),
    .sda_o(host_sda),
    .sda_i(sda)
  );

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic finish_test();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic clks(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // Block write; ok is the AND of every acknowledge
  task automatic blk_write(input logic [6:0] a, input logic [7:0] idx,
                           input logic [7:0] d [$], output logic ok);
    logic k;
    ok = 1'b1;
    i_host.start();
    i_host.send({a, 1'b0}, k);
    ok &= k;
    i_host.send(idx, k);
    ok &= k;
    i_host.send(8'(d.size()), k);
    ok &= k;
    foreach (d[i]) begin
      i_host.send(d[i], k);
      ok &= k;
    end
    i_host.stop();
    clks(4);
  endtask

  // Block read of n bytes into rq
  task automatic blk_read(input logic [7:0] idx, input int n);
    logic k;
    logic ok;
    logic [7:0] b;
    ok = 1'b1;
    rq.delete();
    i_host.start();
    i_host.send({SMB_ADDR_DEFAULT, 1'b0}, k);
    ok &= k;
    i_host.send(idx, k);
    ok &= k;
    i_host.start();
    i_host.send({SMB_ADDR_DEFAULT, 1'b1}, k);
    ok &= k;
    `CHK(ok, 1'b1, "read header not acked")
    i_host.recv(1'b1, b);
    `CHK(b, READ_COUNT_DEFAULT, "read byte count")
    for (int i = 0; i < n; i++) begin
      i_host.recv(i < n - 1, b);
      rq.push_back(b);
    end
    i_host.stop();
    clks(4);
  endtask

  task automatic chk_rd(input logic [7:0] idx, input logic [7:0] e0, input logic [7:0] e1);
    blk_read(idx, 2);
    `CHK(rq[0], e0, "first read byte")
    `CHK(rq[1], e1, "second read byte")
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_powerup();
    `CHK(pll_mode, MODE_HBW, "loop mode reset value")
    supply = 1'b1;
    clks(6);
    pg = 1'b1;
    clks(STUP + 30);
    `CHK(ready, 1'b0, "ready without reference")
    `CHK(pair_en, 6'h00, "outputs without reference")
    `CHK(f100, 1'b1, "frequency strap latch")
    ref_ok = 1'b1;
    clks(10);
    `CHK(pll_en, 1'b1, "loop not powered")
    `CHK(ready, 1'b0, "ready before lock")
    lock = 1'b1;
    clks(10);
    `CHK(ready, 1'b1, "ready after lock")
    `CHK(pair_en, 6'h3F, "outputs after lock")
    `CHK(pll_mode, MODE_BYPASS, "loop mode from strap")
  endtask

  // Power cycle with changed straps: delay span, no relatch
  task automatic t_timing();
    int n;
    supply = 1'b0;
    pg = 1'b0;
    fsel = 1'b0;
    bw = MODE_HBW;
    clks(8);
    `CHK(ready, 1'b0, "ready with supply off")
    supply = 1'b1;
    clks(6);
    pg = 1'b1;
    n = 6;
    while (ready !== 1'b1 && n < STUP + 200) begin
      clks(1);
      n++;
    end
    `CHK(n >= STUP && n <= STUP + 20, 1'b1, "start-up delay span")
    `CHK(n < POWERUP_BUDGET_NS / CLK_PERIOD_NS, 1'b1, "power-up budget")
    `CHK(f100, 1'b1, "frequency strap relatched")
    `CHK(pll_mode, MODE_BYPASS, "mode strap relatched")
  endtask

  task automatic t_mode();
    logic ok;
    chk_rd(IDX_MODE, 8'h47, 8'hF7);
    blk_write(SMB_ADDR_DEFAULT, IDX_MODE, '{8'hB9}, ok);
    `CHK(ok, 1'b1, "write not acked")
    `CHK(pll_mode, MODE_LBW, "software low band")
    chk_rd(IDX_MODE, 8'h49, 8'hF7);
    blk_write(SMB_ADDR_DEFAULT, IDX_MODE, '{8'h0A}, ok);
    `CHK(pll_mode, MODE_BYPASS, "software bypass")
    blk_write(SMB_ADDR_DEFAULT, IDX_MODE, '{8'h0E}, ok);
    `CHK(pll_mode, MODE_HBW, "software high band")
    // warm reset before relying on new mode
    pg = 1'b0;
    clks(6);
    `CHK(ready, 1'b0, "ready during warm reset")
    pg = 1'b1;
    clks(10);
    `CHK(ready, 1'b1, "ready after warm reset")
    `CHK(pll_mode, MODE_HBW, "software mode after warm reset")
    // Software bits differ from strap so a stuck override shows
    blk_write(SMB_ADDR_DEFAULT, IDX_MODE, '{8'h06}, ok);
    `CHK(pll_mode, MODE_BYPASS, "strap mode back")
  endtask

  task automatic t_enables();
    logic ok;
    blk_write(SMB_ADDR_DEFAULT, IDX_MODE, '{8'h06, 8'h5A}, ok);
    `CHK(ok, 1'b1, "block write not acked")
    oe_n = 6'h04;
    clks(6);
    `CHK(pair_en, 6'h11, "enable bits and pins")
    chk_rd(IDX_MODE, 8'h47, 8'h53);
    oe_n = 6'h00;
  endtask

  // Foreign address, unmapped index, reserved bits
  task automatic t_refuse();
    logic ok;
    blk_write(SMB_ADDR_DEFAULT + 7'h01, IDX_OEN, '{8'hFF}, ok);
    `CHK(ok, 1'b0, "foreign address acked")
    blk_write(SMB_ADDR_DEFAULT, 8'h05, '{8'hFF}, ok);
    chk_rd(8'h05, UNMAPPED_BYTE, UNMAPPED_BYTE);
    chk_rd(IDX_OEN, 8'h53, UNMAPPED_BYTE);
    blk_write(SMB_ADDR_DEFAULT, IDX_OEN, '{8'h08}, ok);
    `CHK(pair_en, 6'h00, "pairs not held low")
    chk_rd(IDX_OEN, 8'h01, UNMAPPED_BYTE);
  endtask

  // Main sequence
  initial begin
    clks(8);
    resetn_i = 1'b1;
    clks(4);
    t_powerup();
    t_timing();
    t_mode();
    t_enables();
    t_refuse();
    finish_test();
  end

  // Watchdog well beyond the expected link traffic
  initial begin
    #500_000;
    miscompares++;
    finish_test();
  end
endmodule
